//--- rtl/pawk_defines.svh
`ifndef PAWK_DEFINES_SVH
`define PAWK_DEFINES_SVH

// register byte addresses
`define PAWK_ADDR_PORT_DATA   8'h00
`define PAWK_ADDR_DIRECTION   8'h04
`define PAWK_ADDR_ANALOG_SEL  8'h08
`define PAWK_ADDR_POWER_CTRL  8'h0C
`define PAWK_ADDR_IRQ_FLAGS   8'h10
`define PAWK_ADDR_IRQ_ENABLE  8'h14
`define PAWK_ADDR_PIN_FUNC    8'h18
`define PAWK_ADDR_WAKE_CTRL   8'h1C

// reset values
`define PAWK_RST_ANALOG_SEL   8'hFF
`define PAWK_RST_DIRECTION    8'hFF
`define PAWK_RST_PORT_LATCH   8'h00
`define PAWK_RST_POWER_CTRL   8'h00
`define PAWK_RST_PIN_FUNC     16'h0000

// power control fields
`define PAWK_POWER_CONTROL_SINK_BIT    5
`define PAWK_POWER_CONTROL_SBOR_BIT    4
`define PAWK_POWER_CONTROL_POR_BIT     1
`define PAWK_POWER_CONTROL_BOR_BIT     0

// interrupt flag fields
`define PAWK_IRQ_WAKE_BIT     0
`define PAWK_IRQ_CHANGE_BIT   1

// wake control fields
`define PAWK_WCTL_SLEEP_BIT   0
`define PAWK_WCTL_GIE_BIT     1

// interrupt vector address
`define PAWK_IRQ_VECTOR       13'h0004

`endif

//--- rtl/pawk_pin_sync.sv
`timescale 1ns/1ns

// three-stage synchroniser, change counted when stages two and three agree
module pawk_pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			sync_o <= '0;
		end else begin
			s1_reg <= async_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			sync_o <= (s2_reg & s3_reg) | (sync_o & (s2_reg | s3_reg));
		end
	end

endmodule

//--- rtl/pawk_pkg.sv
package pawk_pkg;

	// function selects per pin, two bits each
	typedef enum logic [1:0] {
		PAWK_FN_GPIO = 2'b00,
		PAWK_FN_ALT1 = 2'b01,
		PAWK_FN_ALT2 = 2'b10,
		PAWK_FN_ALT3 = 2'b11
	} pawk_func_type;

	typedef enum logic [1:0] {
		PAWK_PWR_RUN   = 2'b00,
		PAWK_PWR_SLEEP = 2'b01,
		PAWK_PWR_WAKE  = 2'b10
	} pawk_pwr_type;

endpackage

//--- rtl/pawk_port_a.sv
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "pawk_defines.svh"

module pawk_port_a #(
	parameter bit REDUCED_PINS = 1'b0
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  pin_i,
	output logic      [7:0]  pin_o,
	output logic      [7:0]  pin_oe_o,
	output logic      [7:0]  pullup_en_o,
	output logic      [7:0]  analog_en_o,
	output logic             wake_sink_en_o,
	output logic             timer0_ext_clock_o,
	output logic             slave_select_o,
	output logic             adc_vref_neg_sel_o,
	output logic             adc_vref_pos_sel_o,
	output logic             comparator_ref_voltage_out_en_o,
	output logic             osc_pins_en_o,
	input  wire logic        comparator1_output_i,
	input  wire logic        comparator2_output_i,
	input  wire logic        clock_output_i,
	input  wire logic        clock_ext_in_sel_i,
	input  wire logic [7:0]  pullup_req_i,
	output logic             wake_event_o,
	output logic             vector_take_o,
	output logic [12:0]      vector_addr_o,
	output logic             irq_o
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	localparam logic [7:0] ANS_MASK = REDUCED_PINS ? 8'h1F : 8'hFF;

	logic [7:0]  analog_select_low_reg;
	logic [7:0]  port_a_direction_reg;
	logic [7:0]  port_latch_reg;
	logic [7:0]  power_control_reg;
	logic [1:0]  irq_flag_reg;
	logic [1:0]  irq_enable_reg;
	logic [15:0] pin_func_reg;
	logic        global_irq_enable_reg;
	logic        sleep_req;
	pawk_pkg::pawk_pwr_type pwr_state_reg;
	logic [7:0]  pin_sync;
	logic [7:0]  pin_prev_reg;
	logic [7:0]  digital_in;
	logic        wb_hit;
	logic        wb_wr;
	logic        wb_rd;
	logic        wake_evt;
	logic        change_evt;
	logic [7:0]  wdat;
	logic [1:0]  irq_flag_next;

	pawk_pin_sync #(
		.WIDTH(8)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i(pin_i),
		.sync_o (pin_sync)
	);

	// digital input buffer gated by analog select
	assign digital_in = pin_sync & ~(analog_select_low_reg & ANS_MASK);

	// ---------------------------------------------------------------
	// wishbone slave
	// ---------------------------------------------------------------
	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_hit & wb_we_i & wb_sel_i[0];
	assign wb_rd  = wb_hit & ~wb_we_i;
	assign wdat   = wb_dat_i[7:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= 32'h0000_0000;
			if (wb_rd) begin
				case (wb_adr_i)
					`PAWK_ADDR_PORT_DATA: wb_dat_o[7:0] <= digital_in;
					`PAWK_ADDR_DIRECTION: wb_dat_o[7:0] <= port_a_direction_reg;
					`PAWK_ADDR_ANALOG_SEL: begin
						wb_dat_o[7:0] <= analog_select_low_reg & ANS_MASK;
					end
					`PAWK_ADDR_POWER_CTRL: wb_dat_o[7:0] <= power_control_reg;
					`PAWK_ADDR_IRQ_FLAGS: wb_dat_o[1:0] <= irq_flag_reg;
					`PAWK_ADDR_IRQ_ENABLE: wb_dat_o[1:0] <= irq_enable_reg;
					`PAWK_ADDR_PIN_FUNC: wb_dat_o[15:0] <= pin_func_reg;
					`PAWK_ADDR_WAKE_CTRL: begin
						wb_dat_o[`PAWK_WCTL_GIE_BIT] <= global_irq_enable_reg;
						wb_dat_o[`PAWK_WCTL_SLEEP_BIT] <=
							(pwr_state_reg == pawk_pkg::PAWK_PWR_SLEEP);
					end
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			analog_select_low_reg <= `PAWK_RST_ANALOG_SEL;
		end else if (wb_wr && wb_adr_i == `PAWK_ADDR_ANALOG_SEL) begin
			analog_select_low_reg <= wdat & ANS_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_a_direction_reg <= `PAWK_RST_DIRECTION;
		end else if (wb_wr && wb_adr_i == `PAWK_ADDR_DIRECTION) begin
			port_a_direction_reg <= wdat;
		end
	end

	// full write replaces latch; bit-set/clear style uses masked read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_latch_reg <= `PAWK_RST_PORT_LATCH;
		end else if (wb_wr && wb_adr_i == `PAWK_ADDR_PORT_DATA) begin
			port_latch_reg <= wdat;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_control_reg <= `PAWK_RST_POWER_CTRL;
		end else if (wb_wr && wb_adr_i == `PAWK_ADDR_POWER_CTRL) begin
			power_control_reg[`PAWK_POWER_CONTROL_SINK_BIT] <= wdat[`PAWK_POWER_CONTROL_SINK_BIT];
			power_control_reg[`PAWK_POWER_CONTROL_SBOR_BIT] <= wdat[`PAWK_POWER_CONTROL_SBOR_BIT];
			power_control_reg[`PAWK_POWER_CONTROL_POR_BIT]  <= wdat[`PAWK_POWER_CONTROL_POR_BIT];
			power_control_reg[`PAWK_POWER_CONTROL_BOR_BIT]  <= wdat[`PAWK_POWER_CONTROL_BOR_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_func_reg <= `PAWK_RST_PIN_FUNC;
		end else if (wb_wr && wb_adr_i == `PAWK_ADDR_PIN_FUNC) begin
			pin_func_reg[7:0] <= wdat;
			if (wb_sel_i[1]) begin
				pin_func_reg[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_enable_reg <= 2'b00;
		end else if (wb_wr && wb_adr_i == `PAWK_ADDR_IRQ_ENABLE) begin
			irq_enable_reg <= wdat[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			global_irq_enable_reg <= 1'b0;
		end else if (wb_wr && wb_adr_i == `PAWK_ADDR_WAKE_CTRL) begin
			global_irq_enable_reg <= wdat[`PAWK_WCTL_GIE_BIT];
		end
	end

	assign sleep_req = wb_wr && wb_adr_i == `PAWK_ADDR_WAKE_CTRL
		&& wdat[`PAWK_WCTL_SLEEP_BIT];

	// ---------------------------------------------------------------
	// wake detection and sticky flags
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_prev_reg <= 8'h00;
		end else begin
			pin_prev_reg <= pin_sync;
		end
	end

	// pin0 falling below input-low while sink enabled
	assign wake_evt = power_control_reg[`PAWK_POWER_CONTROL_SINK_BIT]
		& pin_prev_reg[0] & ~pin_sync[0];
	// change on digital pins other than pin0, analog ones excluded
	assign change_evt = |((pin_prev_reg ^ pin_sync)
		& ~(analog_select_low_reg & ANS_MASK) & ~8'h01);

	always_comb begin
		irq_flag_next = irq_flag_reg;
		if (wb_wr && wb_adr_i == `PAWK_ADDR_IRQ_FLAGS) begin
			irq_flag_next = irq_flag_reg & ~wdat[1:0];
		end
		if (wake_evt) begin
			irq_flag_next[`PAWK_IRQ_WAKE_BIT] = 1'b1;
		end
		if (change_evt) begin
			irq_flag_next[`PAWK_IRQ_CHANGE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flag_reg <= 2'b00;
		end else begin
			irq_flag_reg <= irq_flag_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_flag_next & irq_enable_reg);
		end
	end

	// ---------------------------------------------------------------
	// sleep and wake handoff
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_state_reg <= pawk_pkg::PAWK_PWR_RUN;
			wake_event_o  <= 1'b0;
			vector_take_o <= 1'b0;
			vector_addr_o <= 13'h0000;
		end else begin
			wake_event_o  <= 1'b0;
			vector_take_o <= 1'b0;
			case (pwr_state_reg)
				pawk_pkg::PAWK_PWR_RUN: begin
					if (sleep_req) begin
						pwr_state_reg <= pawk_pkg::PAWK_PWR_SLEEP;
					end
				end
				pawk_pkg::PAWK_PWR_SLEEP: begin
					if (|(irq_flag_reg & irq_enable_reg)) begin
						pwr_state_reg <= pawk_pkg::PAWK_PWR_WAKE;
					end
				end
				pawk_pkg::PAWK_PWR_WAKE: begin
					wake_event_o  <= 1'b1;
					vector_take_o <= global_irq_enable_reg;
					vector_addr_o <= `PAWK_IRQ_VECTOR;
					pwr_state_reg <= pawk_pkg::PAWK_PWR_RUN;
				end
				default: pwr_state_reg <= pawk_pkg::PAWK_PWR_RUN;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// pin multiplexing
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o       <= 8'h00;
			pin_oe_o    <= 8'h00;
			pullup_en_o <= 8'h00;
			analog_en_o <= `PAWK_RST_ANALOG_SEL & ANS_MASK;
		end else begin
			for (int i = 0; i < 8; i++) begin
				pin_o[i]       <= port_latch_reg[i];
				pin_oe_o[i]    <= ~port_a_direction_reg[i];
				pullup_en_o[i] <= pullup_req_i[i] & port_a_direction_reg[i]
					& ~(analog_select_low_reg[i] & ANS_MASK[i]);
				analog_en_o[i] <= analog_select_low_reg[i] & ANS_MASK[i];
			end
			pin_oe_o[3] <= 1'b0;
			if (pin_func_reg[9:8] == pawk_pkg::PAWK_FN_ALT2) begin
				pin_o[4]    <= comparator1_output_i;
				pin_oe_o[4] <= 1'b1;
			end
			if (pin_func_reg[11:10] == pawk_pkg::PAWK_FN_ALT3) begin
				pin_o[5]    <= comparator2_output_i;
				pin_oe_o[5] <= 1'b1;
			end
			if (pin_func_reg[13:12] == pawk_pkg::PAWK_FN_ALT2) begin
				pin_o[6]    <= clock_output_i;
				pin_oe_o[6] <= 1'b1;
			end else if (pin_func_reg[13:12] == pawk_pkg::PAWK_FN_ALT1) begin
				pin_oe_o[6] <= 1'b0;
			end
			if (pin_func_reg[15:14] != pawk_pkg::PAWK_FN_GPIO || clock_ext_in_sel_i) begin
				pin_oe_o[7] <= 1'b0;
			end
			if (pin_func_reg[5:4] == pawk_pkg::PAWK_FN_ALT3) begin
				pin_oe_o[2] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_sink_en_o     <= 1'b0;
			timer0_ext_clock_o <= 1'b0;
			slave_select_o     <= 1'b1;
			adc_vref_neg_sel_o <= 1'b0;
			adc_vref_pos_sel_o <= 1'b0;
			comparator_ref_voltage_out_en_o     <= 1'b0;
			osc_pins_en_o      <= 1'b0;
		end else begin
			wake_sink_en_o     <= power_control_reg[`PAWK_POWER_CONTROL_SINK_BIT]
				&& pin_func_reg[1:0] != pawk_pkg::PAWK_FN_GPIO;
			timer0_ext_clock_o <= pin_func_reg[9:8] == pawk_pkg::PAWK_FN_ALT1
				&& pin_sync[4];
			slave_select_o     <= !(pin_func_reg[11:10] == pawk_pkg::PAWK_FN_ALT2)
				|| digital_in[5];
			adc_vref_neg_sel_o <= pin_func_reg[5:4] == pawk_pkg::PAWK_FN_ALT1;
			comparator_ref_voltage_out_en_o     <= pin_func_reg[5:4] == pawk_pkg::PAWK_FN_ALT2;
			adc_vref_pos_sel_o <= pin_func_reg[7:6] == pawk_pkg::PAWK_FN_ALT1;
			osc_pins_en_o      <= pin_func_reg[13:12] == pawk_pkg::PAWK_FN_ALT1;
		end
	end

endmodule

//--- test/pawk_checker_properties.sv
`timescale 1ns/1ns

module pawk_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  pin_oe_o,
	input wire logic [7:0]  pullup_en_o,
	input wire logic [7:0]  analog_en_o,
	input wire logic [7:0]  pullup_req_i,
	input wire logic        wake_event_o,
	input wire logic        vector_take_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pin3; pin_oe_o[3] == 1'b0; endproperty
	a_pin3: assert property (p_pin3) else $error("pin3 driven");
	property p_pu_ana; (pullup_en_o & analog_en_o) == 8'h00; endproperty
	a_pu_ana: assert property (p_pu_ana) else $error("pullup on analog");
	property p_pu_req; (pullup_en_o & ~$past(pullup_req_i)) == 8'h00; endproperty
	a_pu_req: assert property (p_pu_req) else $error("pullup not asked");
	property p_wake_irq; wake_event_o |-> $past(irq_o); endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake without irq");
	property p_wake_pulse; wake_event_o |=> !wake_event_o; endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
	property p_vec; vector_take_o |-> wake_event_o; endproperty
	a_vec: assert property (p_vec) else $error("vector without wake");
	property p_rd_mask;
		wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> (wb_dat_o[7:0] & analog_en_o) == 8'h00;
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("analog pin read high");
	property p_rst_ana; $fell(rst_i) |-> analog_en_o == 8'hFF; endproperty
	a_rst_ana: assert property (p_rst_ana) else $error("analog reset");
	property p_rst_oe; $fell(rst_i) |-> pin_oe_o == 8'h00 && !irq_o; endproperty
	a_rst_oe: assert property (p_rst_oe) else $error("drive reset");
endmodule

bind pawk_port_a pawk_checker chk_u (.*);

//--- test/pawk_rc_net.sv
`timescale 1ns/1ns

module pawk_rc_net #(
	parameter int DISCHARGE = 40
) (
	input  wire logic       clk_i,
	input  wire logic [7:0] pin_o_i,
	input  wire logic [7:0] pin_oe_i,
	input  wire logic [7:0] pullup_i,
	input  wire logic       sink_i,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] lvl_o
);
	logic cap_reg = 1'b1;
	int   cnt_reg = 0;

	// capacitor on pin0: charged while driven, drained by the sink
	always @(posedge clk_i) begin
		if (pin_oe_i[0]) begin
			cap_reg <= pin_o_i[0];
			cnt_reg <= DISCHARGE;
		end else if (sink_i && cnt_reg > 0) begin
			cnt_reg <= cnt_reg - 1;
		end else if (sink_i) begin
			cap_reg <= 1'b0;
		end
	end

	always_comb begin
		lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & (pullup_i | ext_i));
		lvl_o[0] = pin_oe_i[0] ? pin_o_i[0] : cap_reg;
	end
endmodule

//--- test/testbench.sv
`timescale 1ns/1ns
`include "pawk_defines.svh"

module testbench;
	localparam logic [7:0] PD = `PAWK_ADDR_PORT_DATA, DR = `PAWK_ADDR_DIRECTION,
		AS = `PAWK_ADDR_ANALOG_SEL, PC = `PAWK_ADDR_POWER_CTRL, FL = `PAWK_ADDR_IRQ_FLAGS,
		EN = `PAWK_ADDR_IRQ_ENABLE, PF = `PAWK_ADDR_PIN_FUNC, WC = `PAWK_ADDR_WAKE_CTRL;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
	logic [7:0]  wb_adr_i, pin_i, pin_o, pin_oe_o, pullup_en_o, analog_en_o, pullup_req_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0]  wb_sel_i;
	logic        wake_sink_en_o, timer0_ext_clock_o, slave_select_o, adc_vref_neg_sel_o;
	logic        adc_vref_pos_sel_o, comparator_ref_voltage_out_en_o, osc_pins_en_o, comparator1_output_i;
	logic        comparator2_output_i, clock_output_i, clock_ext_in_sel_i, wake_event_o;
	logic        vector_take_o;
	logic [12:0] vector_addr_o;
	logic [7:0]  ext, ana, dir, lat;
	logic [31:0] exp_q[$];
	int          n_errors, samples_checked, k;

	pawk_port_a dut_u (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.wb_cyc_i            (wb_cyc_i),
		.wb_stb_i            (wb_stb_i),
		.wb_we_i             (wb_we_i),
		.wb_adr_i            (wb_adr_i),
		.wb_dat_i            (wb_dat_i),
		.wb_sel_i            (wb_sel_i),
		.wb_dat_o            (wb_dat_o),
		.wb_ack_o            (wb_ack_o),
		.pin_i               (pin_i),
		.pin_o               (pin_o),
		.pin_oe_o            (pin_oe_o),
		.pullup_en_o         (pullup_en_o),
		.analog_en_o         (analog_en_o),
		.wake_sink_en_o      (wake_sink_en_o),
		.timer0_ext_clock_o  (timer0_ext_clock_o),
		.slave_select_o      (slave_select_o),
		.adc_vref_neg_sel_o  (adc_vref_neg_sel_o),
		.adc_vref_pos_sel_o  (adc_vref_pos_sel_o),
		.comparator_ref_voltage_out_en_o      (comparator_ref_voltage_out_en_o),
		.osc_pins_en_o       (osc_pins_en_o),
		.comparator1_output_i(comparator1_output_i),
		.comparator2_output_i(comparator2_output_i),
		.clock_output_i      (clock_output_i),
		.clock_ext_in_sel_i  (clock_ext_in_sel_i),
		.pullup_req_i        (pullup_req_i),
		.wake_event_o        (wake_event_o),
		.vector_take_o       (vector_take_o),
		.vector_addr_o       (vector_addr_o),
		.irq_o               (irq_o)
	);
	pawk_rc_net rc_u (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
		.pullup_i(pullup_en_o), .sink_i(wake_sink_en_o), .ext_i(ext), .lvl_o(pin_i));

	// ------
	// tasks
	// ------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0000_0000);
	endtask

	task automatic nap(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic stop_test;
		if (n_errors == 0 && samples_checked > 0 && exp_q.size() == 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// read results against the oldest noted expectation
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			chk("read", exp_q.pop_front(), wb_dat_o);
	end

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		#400000;
		n_errors++;
		stop_test;
	end

	// ------
	// stimulus
	// ------
	initial begin
		k = $urandom(86);
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hF;
		{comparator1_output_i, comparator2_output_i, clock_output_i, clock_ext_in_sel_i}
			= 4'($urandom());
		pullup_req_i = 8'($urandom());
		ext = 8'($urandom());
		nap(3);
		rst_i <= 1'b0;
		nap(1);
		rd(AS, 8'hFF);
		rd(DR, 8'hFF);
		rd(PC, 8'h00);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 8'h00);
		for (int i = 0; i < 6; i++) begin
			ana = 8'($urandom());
			dir = 8'($urandom());
			lat = 8'($urandom());
			ext = 8'($urandom());
			wr(AS, ana);
			wr(DR, dir);
			wr(PD, lat);
			nap(8);
			chk("oe", ~dir & {~clock_ext_in_sel_i, 7'h77}, pin_oe_o);
			chk("out", lat & ~dir & 8'hF7, pin_o & ~dir & 8'hF7);
			chk("ana", ana, analog_en_o);
			chk("pu", pullup_req_i & dir & ~ana, pullup_en_o);
			rd(PD, pin_i & ~ana);
			rd(AS, ana);
		end
		// software read-modify-write on outputs marked analog
		wr(AS, 8'h0F);
		wr(DR, 8'h00);
		wr(PD, 8'hFF);
		nap(8);
		rd(PD, {clock_ext_in_sel_i ? ext[7] : 1'b1, 7'h70});
		wr(PD, 8'hF1);
		nap(2);
		chk("rmw", 8'hF1, pin_o & 8'hF7);
		chk("oe_ana", {~clock_ext_in_sel_i, 7'h77}, pin_oe_o);
		wr(PF, 16'h1050);
		nap(2);
		chk("vrefn", 1'b1, adc_vref_neg_sel_o);
		chk("vrefp", 1'b1, adc_vref_pos_sel_o);
		chk("osc", 1'b1, osc_pins_en_o);
		wr(PF, 16'h0E20);
		nap(2);
		chk("comparator_ref_voltage", 1'b1, comparator_ref_voltage_out_en_o);
		chk("comparator1_output", comparator1_output_i, pin_o[4]);
		chk("comparator2_output", comparator2_output_i, pin_o[5]);
		wr(PD, 8'h10);
		wr(PF, 16'h0900);
		nap(8);
		chk("t0ck", 1'b1, timer0_ext_clock_o);
		chk("ss", 1'b0, slave_select_o);
		// charge, release, enable, sink, sleep
		wr(AS, 8'h00);
		wr(PF, 16'h0001);
		wr(PD, 8'h01);
		wr(DR, 8'hFE);
		nap(8);
		wr(FL, 8'h03);
		wr(DR, 8'hFF);
		wr(EN, 8'h01);
		wr(PC, 8'h20);
		nap(2);
		chk("sink", 1'b1, wake_sink_en_o);
		wr(WC, 8'h03);
		for (k = 0; k < 200 && wake_event_o !== 1'b1; k++)
			@(posedge clk_i);
		chk("wake", 1'b1, wake_event_o);
		chk("vec", 1'b1, vector_take_o);
		nap(2);
		chk("vaddr", `PAWK_IRQ_VECTOR, vector_addr_o);
		rd(FL, 8'h01);
		chk("irq", 1'b1, irq_o);
		wr(EN, 8'h00);
		nap(2);
		chk("irq_mask", 1'b0, irq_o);
		wr(EN, 8'h01);
		nap(2);
		chk("irq_held", 1'b1, irq_o);
		wr(FL, 8'h01);
		nap(2);
		chk("irq_clr", 1'b0, irq_o);
		rd(FL, 8'h00);
		wr(DR, 8'hFF);
		wr(AS, 8'h01);
		nap(2);
		chk("ana0", 8'h01, analog_en_o);
		nap(4);
		stop_test;
	end
endmodule
